// file: src/power_down_defs.vh
`ifndef POWER_DOWN_DEFS_VH
`define POWER_DOWN_DEFS_VH

// Register indexes; byte address is index times four
`define PD_IDX_CTRL_ONE 16'hFFF0
`define PD_IDX_CTRL_TWO 16'hFFF1
`define PD_ADDR_CTRL_ONE 18'h3FFC0
`define PD_ADDR_CTRL_TWO 18'h3FFC4
`define PD_ADDR_CFG 18'h3FFC8
`define PD_ADDR_STATUS 18'h3FFCC
`define PD_ADDR_ENABLE 18'h3FFD0
`define PD_ADDR_CLEAR 18'h3FFD4
`define PD_ADDR_MODE 18'h3FFD8

// Reset values
`define PD_RST_CTRL_ONE 8'h07
`define PD_RST_CTRL_TWO 8'hF0
`define PD_RST_CFG 16'h0000

// Bits that read as one and cannot be written
`define PD_FIX_CTRL_ONE 8'h04
`define PD_FIX_CTRL_TWO 8'hE0

// Field positions in control one
`define PD_BIT_STANDBY 7
`define PD_BIT_LOW_SPEED 3
// Field positions in control two
`define PD_BIT_DIRECT 3
`define PD_BIT_MEDIUM 2

// Field positions in the peripheral clock select register
`define PD_CFG_TMR_LO 0
`define PD_CFG_TMR_HI 1
`define PD_CFG_SER1_LO 2
`define PD_CFG_SER1_HI 3
`define PD_CFG_SER2_LO 4
`define PD_CFG_SER2_HI 5
`define PD_CFG_WDG_LO 6
`define PD_CFG_WDG_HI 7
`define PD_CFG_LCD_LO 8
`define PD_CFG_LCD_HI 9
`define PD_CFG_TIMEBASE 10
`define PD_CFG_WATCH_SEL 11

// Clock select codes
`define PD_TMR_EXT 2'h1
`define PD_TMR_W4 2'h2
`define PD_SER_W2 2'h1
`define PD_WDG_W32 2'h1
`define PD_LCD_W 2'h1
`define PD_LCD_W2 2'h2
`define PD_LCD_W4 2'h3

// Mode codes, one-hot
`define PD_M_ACTIVE 7'h01
`define PD_M_SLEEP 7'h02
`define PD_M_WATCH 7'h04
`define PD_M_SUBACT 7'h08
`define PD_M_SUBSLEEP 7'h10
`define PD_M_STANDBY 7'h20
`define PD_M_MEDIUM 7'h40

`endif

// file: src/power_down_state_control.v
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
`include "power_down_defs.vh"
module power_down_state_control
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [17:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   output wire wb_err_o,
   // CPU side
   input wire sleepExec,
   input wire wakeIrq,
   input wire subTimerFlag,
   // External interrupt pins, bit 0 always live
   input wire [4:0] irqPin,
   input wire [7:0] wakeupPins,
   input wire [4:0] irqFlagIn,
   output wire [4:0] irqSetReq,
   // Event counter
   input wire eventCountReq,
   output wire eventIrqReq,
   // Port pins
   input wire [7:0] portReg,
   output wire [7:0] portOut,
   output wire [7:0] portOe,
   // Peripheral run enables
   output wire sysClkRun,
   output wire cpuRun,
   output wire intervalTimerRun,
   output wire captureTimerRun,
   output wire generalTimerRun,
   output wire serialOneRun,
   output wire serialTwoRun,
   output wire serialReset,
   output wire watchdogRun,
   output wire displayRun,
   output wire pwmRun,
   output wire adcRun,
   // Interrupt
   output wire irq
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, accepted when stages two and three agree
   // A pulse shorter than two clocks never reaches the edge logic
   reg [4:0] irqS1_q, irqS2_q, irqS3_q, irqV_q;
   reg [7:0] wakeS1_q, wakeS2_q, wakeS3_q, wakeV_q;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irqS1_q <= 5'h00;
         irqS2_q <= 5'h00;
         irqS3_q <= 5'h00;
         irqV_q <= 5'h00;
         wakeS1_q <= 8'h00;
         wakeS2_q <= 8'h00;
         wakeS3_q <= 8'h00;
         wakeV_q <= 8'h00;
      end
      else
      begin
         irqS1_q <= irqPin;
         irqS2_q <= irqS1_q;
         irqS3_q <= irqS2_q;
         irqV_q <= (irqS2_q & irqS3_q) | (irqV_q & (irqS2_q | irqS3_q));
         wakeS1_q <= wakeupPins;
         wakeS2_q <= wakeS1_q;
         wakeS3_q <= wakeS2_q;
         wakeV_q <= (wakeS2_q & wakeS3_q) | (wakeV_q & (wakeS2_q | wakeS3_q));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   reg [7:0] ctrlOne_q;
   reg [7:0] ctrlTwo_q;
   reg [15:0] cfg_q;
   reg [3:0] irqEn_q;
   reg [6:0] mode_q;
   reg [6:0] mode_d;
   reg ack_q;
   wire [3:0] status;
   wire access = wb_cyc_i & wb_stb_i & ~ack_q;
   // Address decode; any other address is answered with err
   wire hitOne = wb_adr_i == `PD_ADDR_CTRL_ONE;
   wire hitTwo = wb_adr_i == `PD_ADDR_CTRL_TWO;
   wire hitCfg = wb_adr_i == `PD_ADDR_CFG;
   wire hitSts = wb_adr_i == `PD_ADDR_STATUS;
   wire hitEn = wb_adr_i == `PD_ADDR_ENABLE;
   wire hitClr = wb_adr_i == `PD_ADDR_CLEAR;
   wire hitMode = wb_adr_i == `PD_ADDR_MODE;
   wire mapped = hitOne | hitTwo | hitCfg | hitSts | hitEn | hitClr | hitMode;
   wire wrOk = access & wb_we_i & mapped;
   wire [3:0] clrPulse = (wrOk & hitClr & wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

   // Answer in the cycle after the request; unmapped addresses get err
   reg err_q;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
      end
      else
      begin
         ack_q <= access & mapped & ~ack_q;
         err_q <= access & ~mapped & ~err_q;
      end
   end
   // Both answers are registered one-cycle pulses
   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;

   // Writable registers; reserved bits stay one
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrlOne_q <= `PD_RST_CTRL_ONE;
         ctrlTwo_q <= `PD_RST_CTRL_TWO;
         cfg_q <= `PD_RST_CFG;
         irqEn_q <= 4'h0;
      end
      else if (wrOk)
      begin
         if (hitOne && wb_sel_i[0])
            ctrlOne_q <= wb_dat_i[7:0] | `PD_FIX_CTRL_ONE;
         if (hitTwo && wb_sel_i[0])
            ctrlTwo_q <= wb_dat_i[7:0] | `PD_FIX_CTRL_TWO;
         if (hitCfg && wb_sel_i[0])
            cfg_q[7:0] <= wb_dat_i[7:0];
         if (hitCfg && wb_sel_i[1])
            cfg_q[15:8] <= wb_dat_i[15:8];
         if (hitEn && wb_sel_i[0])
            irqEn_q <= wb_dat_i[3:0];
      end
   end

   // Read data is registered with the ack
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wb_dat_o <= 32'h00000000;
      else if (access)
      begin
         if (hitOne)
            wb_dat_o <= {24'h000000, ctrlOne_q};
         else if (hitTwo)
            wb_dat_o <= {24'h000000, ctrlTwo_q};
         else if (hitCfg)
            wb_dat_o <= {16'h0000, cfg_q};
         else if (hitSts)
            wb_dat_o <= {28'h0000000, status};
         else if (hitEn)
            wb_dat_o <= {28'h0000000, irqEn_q};
         else if (hitMode)
            wb_dat_o <= {25'h0000000, mode_q};
         else
            wb_dat_o <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode machine
   // Control fields that steer the sleep instruction
   wire standbyBit = ctrlOne_q[`PD_BIT_STANDBY];
   wire lowSpeedBit = ctrlOne_q[`PD_BIT_LOW_SPEED];
   wire directBit = ctrlTwo_q[`PD_BIT_DIRECT];
   wire mediumBit = ctrlTwo_q[`PD_BIT_MEDIUM];
   wire watchSel = cfg_q[`PD_CFG_WATCH_SEL];

   // Sleep picks target from control bits; standby versus watch uses the watch select bit
   always @*
   begin
      mode_d = mode_q;
      case (mode_q)
         `PD_M_ACTIVE, `PD_M_MEDIUM:
         begin
            if (sleepExec)
            begin
               if (directBit && standbyBit && lowSpeedBit && watchSel)
                  mode_d = `PD_M_SUBACT;
               else if (directBit && !standbyBit && !lowSpeedBit)
                  mode_d = mediumBit ? `PD_M_MEDIUM : `PD_M_ACTIVE;
               else if (!standbyBit)
                  mode_d = `PD_M_SLEEP;
               else
                  mode_d = watchSel ? `PD_M_WATCH : `PD_M_STANDBY;
            end
         end
         `PD_M_SUBACT:
         begin
            if (sleepExec)
               mode_d = standbyBit ? `PD_M_WATCH : `PD_M_SUBSLEEP;
         end
         `PD_M_SLEEP, `PD_M_STANDBY:
         begin
            if (wakeIrq)
               mode_d = `PD_M_ACTIVE;
         end
         `PD_M_WATCH, `PD_M_SUBSLEEP:
         begin
            if (wakeIrq)
               mode_d = lowSpeedBit ? `PD_M_SUBACT : `PD_M_ACTIVE;
         end
         default:
            mode_d = `PD_M_ACTIVE;
      endcase
   end

   // Mode register; every run enable decodes from it
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_q <= `PD_M_ACTIVE;
      else
         mode_q <= mode_d;
   end

   // Mode decodes
   wire inWatch = mode_q == `PD_M_WATCH;
   wire inSubact = mode_q == `PD_M_SUBACT;
   wire inSubsleep = mode_q == `PD_M_SUBSLEEP;
   wire inStandby = mode_q == `PD_M_STANDBY;
   wire subClkMode = inWatch | inSubact | inSubsleep;
   wire fullClk = ~(subClkMode | inStandby);

   ////////////////////////////////////////////////////////////////////////
   // Run enables
   wire [1:0] tmrSel = cfg_q[`PD_CFG_TMR_HI:`PD_CFG_TMR_LO];
   wire [1:0] ser1Sel = cfg_q[`PD_CFG_SER1_HI:`PD_CFG_SER1_LO];
   wire [1:0] ser2Sel = cfg_q[`PD_CFG_SER2_HI:`PD_CFG_SER2_LO];
   wire [1:0] wdgSel = cfg_q[`PD_CFG_WDG_HI:`PD_CFG_WDG_LO];
   wire [1:0] lcdSel = cfg_q[`PD_CFG_LCD_HI:`PD_CFG_LCD_LO];
   wire tmrOk = (tmrSel == `PD_TMR_EXT) | (tmrSel == `PD_TMR_W4);
   wire lcdOk = (lcdSel == `PD_LCD_W) | (lcdSel == `PD_LCD_W2) | (lcdSel == `PD_LCD_W4);

   // Enables are plain decodes, so they switch in the same cycle as the mode
   assign sysClkRun = fullClk;
   assign cpuRun = (mode_q == `PD_M_ACTIVE) | (mode_q == `PD_M_MEDIUM) | inSubact;
   // Interval timer runs in the subclock modes only while the time base bit is set
   assign intervalTimerRun = fullClk | (subClkMode & cfg_q[`PD_CFG_TIMEBASE]);
   // Capture timer halts in watch; general timers run there only on the quarter watch clock
   assign captureTimerRun = fullClk | ((inSubact | inSubsleep) & tmrOk);
   assign generalTimerRun = fullClk | ((inSubact | inSubsleep) & tmrOk)
      | (inWatch & (tmrSel == `PD_TMR_W4));
   assign serialOneRun = fullClk | ((inSubact | inSubsleep) & (ser1Sel == `PD_SER_W2));
   assign serialTwoRun = fullClk | ((inSubact | inSubsleep) & (ser2Sel == `PD_SER_W2));
   assign serialReset = inWatch | inStandby;
   assign watchdogRun = fullClk | (inSubact & (wdgSel == `PD_WDG_W32));
   assign displayRun = fullClk | (subClkMode & lcdOk);
   assign pwmRun = fullClk;
   assign adcRun = fullClk;

   ////////////////////////////////////////////////////////////////////////
   // Ports float in standby while their registers hold
   assign portOut = portReg;
   assign portOe = inStandby ? 8'h00 : 8'hFF;

   ////////////////////////////////////////////////////////////////////////
   // External interrupt gating: rising edges request a flag set
   reg [4:0] irqPrev_q;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irqPrev_q <= 5'h00;
      else
         irqPrev_q <= irqV_q;
   end
   // Previous value resets to the idle pin level, so reset makes no false edge
   wire [4:0] irqEdge = irqV_q & ~irqPrev_q;
   // Lines one to four are dropped in watch and standby; flag store left untouched
   wire [4:0] irqMask = (inWatch | inStandby) ? 5'h01 : 5'h1F;
   assign irqSetReq = irqEdge & irqMask & ~irqFlagIn;

   // Event counter keeps counting; only its interrupt is suppressed
   assign eventIrqReq = eventCountReq & ~(inWatch | inStandby);

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: wake pin, mode entry, gated event, timer in subclock mode
   reg [7:0] wakePrev_q;
   reg [6:0] modePrev_q;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wakePrev_q <= 8'h00;
         modePrev_q <= `PD_M_ACTIVE;
      end
      else
      begin
         wakePrev_q <= wakeV_q;
         modePrev_q <= mode_q;
      end
   end
   // Wake and mode sources are one-cycle pulses; event and timer sources pass their levels
   wire [3:0] events;
   assign events[0] = |(wakeV_q & ~wakePrev_q);
   assign events[1] = mode_q != modePrev_q;
   assign events[2] = eventIrqReq;
   assign events[3] = subTimerFlag & subClkMode;

   // One sticky bit per event source
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : flagGen
         sticky_flag flagInst
         (
            .clk(clk),
            .rst_n(rst_n),
            .setPulse(events[g]),
            .clrPulse(clrPulse[g]),
            .flag(status[g])
         );
      end
   endgenerate

   // Level output while any enabled bit is set
   assign irq = |(status & irqEn_q);

endmodule

// file: src/sticky_flag.v
`timescale 1ns/1ns
// One status bit: a set in the clear cycle wins
module sticky_flag
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Control
   input wire setPulse,
   input wire clrPulse,
   // State
   output reg flag
);

   // Set has priority so no event is lost
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flag <= 1'b0;
      else if (setPulse)
         flag <= 1'b1;
      else if (clrPulse)
         flag <= 1'b0;
   end

endmodule

// file: tb/pd_check_sva.sv
`timescale 1ns/1ns
module pd_check
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Bus handshake
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire wb_err_o,
   // Mode outputs
   input wire [4:0] irqSetReq,
   input wire eventIrqReq,
   input wire [7:0] portReg,
   input wire [7:0] portOut,
   input wire [7:0] portOe,
   input wire cpuRun,
   input wire captureTimerRun,
   input wire serialReset,
   // Subclock run enables
   input wire sysClkRun,
   input wire serialOneRun,
   input wire serialTwoRun,
   input wire watchdogRun
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   // A fresh request has no answer pending, so one is owed next cycle
   sequence newReq;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence answer;
      wb_ack_o || wb_err_o;
   endsequence
   answer_next_a: assert property (newReq |=> answer) else $error("bus answer missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   answer_cause_a: assert property (answer |-> $past(wb_cyc_i && wb_stb_i)) else $error("answer without request");
   one_answer_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
   ////////////////////////////////////////////////////////////////
   // Serial reset marks watch or standby, the modes that block requests
   port_mirror_a: assert property (portOut == portReg) else $error("port data lost");
   standby_float_a: assert property (portOe == 8'h00 |-> serialReset && !cpuRun)
      else $error("float outside standby");
   retained_irq_a: assert property (serialReset |-> irqSetReq[4:1] == 4'h0)
      else $error("retained line set flag");
   serial_halt_a: assert property (serialReset |-> !serialOneRun && !serialTwoRun)
      else $error("serial channel running");
   wdg_retain_a: assert property (!sysClkRun && !cpuRun |-> !watchdogRun)
      else $error("watchdog counting while halted");
   event_block_a: assert property (serialReset |-> !eventIrqReq) else $error("event irq not blocked");
   capture_halt_a: assert property (serialReset |-> !captureTimerRun) else $error("capture timer running");
endmodule
bind power_down_state_control pd_check chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irqSetReq(irqSetReq), .eventIrqReq(eventIrqReq), .portReg(portReg),
   .portOut(portOut), .portOe(portOe), .cpuRun(cpuRun), .captureTimerRun(captureTimerRun), .serialReset(serialReset),
   .sysClkRun(sysClkRun), .serialOneRun(serialOneRun), .serialTwoRun(serialTwoRun), .watchdogRun(watchdogRun));

// file: tb/testbench.sv
`timescale 1ns/1ns
`include "power_down_defs.vh"
module testbench;
   logic clk, rst_n, cyc, we, sleepExec, wakeIrq, eventCountReq, errSeen;
   logic [17:0] adr;
   logic [31:0] wdat, rdat;
   logic [4:0] irqPin, setSeen;
   logic [11:0] cfgTab [4] = '{12'h800, 12'hD02, 12'hA01, 12'hF00};
   logic [3:0] runTab [4] = '{4'h0, 4'hE, 4'h2, 4'hA};
   wire [31:0] datO;
   wire ack, err, eventIrqReq, irq, cpuRun, itRun, ctRun, gtRun, dispRun, serialReset, s1Run, s2Run, wdRun;
   wire [4:0] irqSetReq;
   wire [7:0] portOut, portOe;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   power_down_state_control dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err),
      .sleepExec(sleepExec), .wakeIrq(wakeIrq), .subTimerFlag(1'b0), .irqPin(irqPin), .wakeupPins(8'h00),
      .irqFlagIn(5'h00), .irqSetReq(irqSetReq), .eventCountReq(eventCountReq), .eventIrqReq(eventIrqReq),
      .portReg(8'hA5), .portOut(portOut), .portOe(portOe), .sysClkRun(), .cpuRun(cpuRun),
      .intervalTimerRun(itRun), .captureTimerRun(ctRun), .generalTimerRun(gtRun), .serialOneRun(s1Run),
      .serialTwoRun(s2Run), .serialReset(serialReset), .watchdogRun(wdRun), .displayRun(dispRun), .pwmRun(),
      .adcRun(), .irq(irq));
   ////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         results;
      end
   end
   ////////////////////////////////////////////////////////////////
   task results;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic cycle: request held until ack or err is sampled high
   task automatic wb(input logic [17:0] a, input logic w, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && err !== 1'b1)
         @(posedge clk);
      rdat = datO;
      errSeen = err;
      cyc <= 1'b0;
      @(posedge clk);
   endtask
   // Only the low byte is compared; upper read bits are unspecified
   task automatic rd(input logic [17:0] a, input logic [7:0] e);
      wb(a, 1'b0, 32'h0);
      chk({24'h0, rdat[7:0]}, {24'h0, e});
   endtask
   task automatic doReset;
      rst_n <= 1'b0;
      irqPin <= 5'h00;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   task automatic wake;
      wakeIrq <= 1'b1;
      @(posedge clk);
      wakeIrq <= 1'b0;
      @(posedge clk);
   endtask
   task automatic sleep;
      sleepExec <= 1'b1;
      @(posedge clk);
      sleepExec <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      {cyc, we, sleepExec, wakeIrq, eventCountReq, adr, wdat} = '0;
      doReset;
      // Reset values, then fixed reserved bits
      rd(`PD_ADDR_CTRL_ONE, `PD_RST_CTRL_ONE);
      rd(`PD_ADDR_CTRL_TWO, `PD_RST_CTRL_TWO);
      wb(`PD_ADDR_CTRL_ONE, 1'b1, 32'h0);
      rd(`PD_ADDR_CTRL_ONE, 8'h04);
      wb(`PD_ADDR_CTRL_TWO, 1'b1, 32'h0);
      rd(`PD_ADDR_CTRL_TWO, 8'hE0);
      wb(`PD_ADDR_CTRL_ONE, 1'b1, 32'hFF);
      rd(`PD_ADDR_CTRL_ONE, 8'hFF);
      wb(18'h3FFFC, 1'b0, 32'h0);
      chk({31'h0, errSeen}, 32'h1);
      // Standby bit clear: sleep, mode change raises irq until masked or cleared
      wb(`PD_ADDR_CTRL_ONE, 1'b1, 32'h07);
      wb(`PD_ADDR_ENABLE, 1'b1, 32'h02);
      sleep;
      rd(`PD_ADDR_MODE, `PD_M_SLEEP);
      chk({22'h0, cpuRun, portOe, irq}, {22'h0, 1'b0, 8'hFF, 1'b1});
      wb(`PD_ADDR_ENABLE, 1'b1, 32'h00);
      chk({31'h0, irq}, 32'h0);
      wb(`PD_ADDR_ENABLE, 1'b1, 32'h02);
      wb(`PD_ADDR_CLEAR, 1'b1, 32'h02);
      rd(`PD_ADDR_STATUS, 8'h00);
      chk({31'h0, irq}, 32'h0);
      // Wake interrupt leaves sleep for active
      wake;
      rd(`PD_ADDR_MODE, `PD_M_ACTIVE);
      // Standby bit set, watch select clear: standby floats the port
      doReset;
      eventCountReq <= 1'b1;
      wb(`PD_ADDR_CTRL_ONE, 1'b1, 32'h87);
      sleep;
      rd(`PD_ADDR_MODE, `PD_M_STANDBY);
      chk({14'h0, portOe, portOut, eventIrqReq, itRun}, {14'h0, 8'h00, 8'hA5, 2'b00});
      // Watch mode across clock selects; retained lines must not set flags
      for (int i = 0; i < 4; i++)
      begin
         doReset;
         wb(`PD_ADDR_CFG, 1'b1, {20'h0, cfgTab[i]});
         wb(`PD_ADDR_CTRL_ONE, 1'b1, 32'h87);
         sleep;
         rd(`PD_ADDR_MODE, `PD_M_WATCH);
         chk({28'h0, itRun, gtRun, dispRun, ctRun}, {28'h0, runTab[i]});
         chk({31'h0, eventIrqReq}, 32'h0);
         setSeen = 5'h00;
         irqPin <= 5'h1F;
         repeat (6)
         begin
            @(posedge clk);
            setSeen = setSeen | irqSetReq;
         end
         chk({27'h0, setSeen}, 32'h1);
      end
      // Direct sleep to subactive: timers on external, serial one on w/2, watchdog on w/32
      doReset;
      wb(`PD_ADDR_CFG, 1'b1, 32'h00000845);
      wb(`PD_ADDR_CTRL_TWO, 1'b1, 32'h08);
      wb(`PD_ADDR_CTRL_ONE, 1'b1, 32'h88);
      sleep;
      rd(`PD_ADDR_MODE, `PD_M_SUBACT);
      chk({25'h0, cpuRun, ctRun, gtRun, s1Run, s2Run, wdRun, dispRun}, 32'h7A);
      // Standby bit clear in subactive: subsleep holds the watchdog
      wb(`PD_ADDR_CTRL_ONE, 1'b1, 32'h08);
      sleep;
      rd(`PD_ADDR_MODE, `PD_M_SUBSLEEP);
      chk({25'h0, cpuRun, ctRun, gtRun, s1Run, s2Run, wdRun, dispRun}, 32'h38);
      // Low-speed bit set: wake returns to subactive
      wake;
      rd(`PD_ADDR_MODE, `PD_M_SUBACT);
      results;
   end
endmodule
